// ==== core/btr_pkg.sv ====
package btr_pkg;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [7:0]  IDX_STAT   = 8'h01;
  localparam logic [7:0]  IDX_INTF   = 8'h0c;
  localparam logic [7:0]  IDX_CTL0   = 8'h90;
  localparam logic [7:0]  IDX_CTL1   = 8'h91;
  localparam logic [7:0]  IDX_SRC0   = 8'hc0;
  localparam logic [7:0]  IDX_SRC1   = 8'hc1;
  localparam logic [7:0]  IDX_DEST   = 8'hc2;
  localparam logic [7:0]  IDX_LEN    = 8'hc3;
  localparam logic [7:0]  IDX_ALPHA  = 8'hc4;
  localparam logic [7:0]  IDX_HDATA  = 8'hc5;
  localparam logic [7:0]  IDX_MADDR  = 8'hc6;
  localparam logic [7:0]  IDX_MDATA  = 8'hc7;
  localparam logic [7:0]  IDX_FG     = 8'hd2;
  localparam logic [7:0]  IDX_BG     = 8'hd5;

  // Field positions.
  localparam int unsigned CTL0_GO_BIT   = 4;
  localparam int unsigned STAT_BUSY_BIT = 3;
  localparam int unsigned INTF_BTE_BIT  = 1;
  localparam int unsigned ROP_LSB       = 4;

  // Operation select codes.
  localparam logic [3:0]  OP_HOST_ROP   = 4'h0;
  localparam logic [3:0]  OP_MEM_ROP    = 4'h2;
  localparam logic [3:0]  OP_HOST_KEY   = 4'h4;
  localparam logic [3:0]  OP_MEM_KEY    = 4'h5;
  localparam logic [3:0]  OP_PAT_ROP    = 4'h6;
  localparam logic [3:0]  OP_PAT_KEY    = 4'h7;
  localparam logic [3:0]  OP_HOST_EXP   = 4'h8;
  localparam logic [3:0]  OP_HOST_EXPK  = 4'h9;
  localparam logic [3:0]  OP_MEM_BLEND  = 4'ha;
  localparam logic [3:0]  OP_HOST_BLEND = 4'hb;
  localparam logic [3:0]  OP_FILL       = 4'hc;
  localparam logic [3:0]  OP_MEM_EXP    = 4'he;
  localparam logic [3:0]  OP_MEM_EXPK   = 4'hf;

  // Sizes and reset values.
  localparam logic [4:0]  ALPHA_FULL  = 5'h10;
  localparam logic [2:0]  PAT_MASK    = 3'h7;
  localparam logic [7:0]  CTL1_RST    = 8'h00;
  localparam logic [15:0] PIX_RST     = 16'h0000;
  localparam logic [6:0]  LEN_RST     = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } btr_fsm_t;

  typedef struct packed {
    logic [7:0]        ctl1;
    logic [15:0]       fg;
    logic [15:0]       bg;
    logic [4:0]        alpha;
    logic [5:0]        s0a;
    logic [5:0]        s1a;
    logic [5:0]        dta;
    logic [5:0]        maddr;
    logic [6:0]        len;
    logic [6:0]        cnt;
    logic [5:0]        sp;
    logic [3:0]        bi;
    logic [15:0]       word;
    logic              wv;
    logic [15:0]       hd;
    logic              hv;
    logic              irqf;
    logic              intn;
    btr_fsm_t          fsm;
    logic              aw;
    logic [11:0]       aa;
    logic              rdy;
    logic [31:0]       rd;
    logic [63:0][15:0] ram;
  } btr_state_t;

endpackage

// ==== core/btr_engine.sv ====
// Function
// - Op 0000b host pixels, op 0010b memory pixels, both through the raster function.
// - Op 0100b host pixels, op 0101b memory pixels, keyed, no raster function.
// - Op 0110b tiles a pattern through raster function; 0111b tiles it keyed.
// - Op 1000b expands host bits to colour; 1001b adds keying.
// - Op 1110b expands memory bits to colour; 1111b adds keying.
// - Op 1010b/1011b alpha-blend memory or host first source; 1100b solid fill.
// - Raster 1100b passes first, 0011b/0101b invert first/second, 1010b passes second.
// - Raster 1110b OR, 1000b AND, 0110b XOR, 1001b XNOR.
// - Raster 0001b NOR, 0000b zeros, 1111b ones, 0010b not-first AND second.
// - Raster 0111b NAND, 0100b first AND not second, 1011b, 1101b mixed ORs.
// - First source from host or memory; second source and destination in memory.
// - In expansion ops the raster field picks the start bit of the first source word; later words start at bit 0.
// - Engine stays busy until done, shown on control-zero bit 4, status bit 3.
// - Completion drives the active-low interrupt; flag register 0Ch shows the source.
// - Expansion: one bits give foreground, zero bits background or skip if transparent.
// - Keying skips destination writes where first source equals background colour.
//
// Local design decision: the AHB-Lite register port.
module btr_engine (
  // Clock, reset and freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Completion interrupt
  output logic             int_n
);

  btr_pkg::btr_state_t s_q;
  btr_pkg::btr_state_t s_d;

  logic [3:0]  op;
  logic [3:0]  raster_function;
  logic        go;
  logic        wen;
  logic [15:0] wdata;
  logic [15:0] s0;
  logic [15:0] s1;
  logic [5:0]  widx;
  logic        ebit;
  logic        start;
  logic [11:0] ba;

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  function automatic logic op_ok(input logic [3:0] o);
    return o inside {btr_pkg::OP_HOST_ROP, btr_pkg::OP_MEM_ROP, btr_pkg::OP_HOST_KEY,
                     btr_pkg::OP_MEM_KEY, btr_pkg::OP_PAT_ROP, btr_pkg::OP_PAT_KEY,
                     btr_pkg::OP_HOST_EXP, btr_pkg::OP_HOST_EXPK, btr_pkg::OP_MEM_BLEND,
                     btr_pkg::OP_HOST_BLEND, btr_pkg::OP_FILL, btr_pkg::OP_MEM_EXP,
                     btr_pkg::OP_MEM_EXPK};
  endfunction

  function automatic logic is_exp(input logic [3:0] o);
    return o inside {btr_pkg::OP_HOST_EXP, btr_pkg::OP_HOST_EXPK,
                     btr_pkg::OP_MEM_EXP, btr_pkg::OP_MEM_EXPK};
  endfunction

  function automatic logic is_rop(input logic [3:0] o);
    return o inside {btr_pkg::OP_HOST_ROP, btr_pkg::OP_MEM_ROP, btr_pkg::OP_PAT_ROP};
  endfunction

  function automatic logic is_key(input logic [3:0] o);
    return o inside {btr_pkg::OP_HOST_KEY, btr_pkg::OP_MEM_KEY, btr_pkg::OP_PAT_KEY,
                     btr_pkg::OP_HOST_EXPK, btr_pkg::OP_MEM_EXPK};
  endfunction

  // Ops whose first source arrives through the host data register.
  function automatic logic is_host(input logic [3:0] o);
    return o inside {btr_pkg::OP_HOST_ROP, btr_pkg::OP_HOST_KEY, btr_pkg::OP_HOST_EXP,
                     btr_pkg::OP_HOST_EXPK, btr_pkg::OP_HOST_BLEND};
  endfunction

  function automatic logic [15:0] rop_f(input logic [3:0] c, input logic [15:0] a, b);
    case (c)
      4'h0: return 16'h0000;
      4'h1: return ~(a | b);
      4'h2: return ~a & b;
      4'h3: return ~a;
      4'h4: return a & ~b;
      4'h5: return ~b;
      4'h6: return a ^ b;
      4'h7: return ~(a & b);
      4'h8: return a & b;
      4'h9: return ~(a ^ b);
      4'ha: return b;
      4'hb: return ~a | b;
      4'hc: return a;
      4'hd: return a | ~b;
      4'he: return a | b;
      default: return 16'hffff;
    endcase
  endfunction

  // Pixels are RGB 5:6:5; each channel is blended on its own so no carry leaks across.
  function automatic logic [15:0] blend_f(input logic [15:0] a, b, input logic [4:0] al);
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] u;
    logic [4:0]  nl;
    nl = btr_pkg::ALPHA_FULL - al;
    r  = 12'(al) * 12'(a[15:11]) + 12'(nl) * 12'(b[15:11]);
    g  = 12'(al) * 12'(a[10:5]) + 12'(nl) * 12'(b[10:5]);
    u  = 12'(al) * 12'(a[4:0]) + 12'(nl) * 12'(b[4:0]);
    return {r[8:4], g[9:4], u[8:4]};
  endfunction

  assign op  = s_q.ctl1[3:0];
  assign raster_function = s_q.ctl1[7:btr_pkg::ROP_LSB];
  assign ba  = haddr[11:0];

  always_comb
  begin
    s_d   = s_q;
    go    = 1'b0;
    wen   = 1'b0;
    wdata = 16'h0000;
    start = 1'b0;
    ebit  = s_q.word[s_q.bi];
    s1    = s_q.ram[s_q.s1a + s_q.cnt[5:0]];
    widx  = s_q.dta + s_q.cnt[5:0];
    s0    = s_q.hd;
    if (s_q.fsm == btr_pkg::ST_RUN)
    begin
      if (is_exp(op))
      begin
        if (!s_q.wv)
        begin
          // A fresh source word is fetched before any of its bits are expanded.
          if (is_host(op) && s_q.hv)
          begin
            s_d.word = s_q.hd;
            s_d.wv   = 1'b1;
            s_d.hv   = 1'b0;
          end
          else if (!is_host(op))
          begin
            s_d.word = s_q.ram[s_q.sp];
            s_d.sp   = s_q.sp + 6'h01;
            s_d.wv   = 1'b1;
          end
        end
        else
        begin
          go    = 1'b1;
          wen   = ebit | !is_key(op);
          wdata = ebit ? s_q.fg : s_q.bg;
          s_d.bi = s_q.bi + 4'h1;
          if (s_q.bi == 4'hf)
          begin
            s_d.wv = 1'b0;
          end
        end
      end
      else
      begin
        if (is_host(op))
        begin
          go = s_q.hv;
          if (s_q.hv)
          begin
            s_d.hv = 1'b0;
          end
        end
        else if (op == btr_pkg::OP_PAT_ROP || op == btr_pkg::OP_PAT_KEY)
        begin
          go = 1'b1;
          s0 = s_q.ram[s_q.s0a + {3'h0, s_q.cnt[2:0] & btr_pkg::PAT_MASK}];
        end
        else
        begin
          go = 1'b1;
          s0 = s_q.ram[s_q.sp];
          s_d.sp = s_q.sp + 6'h01;
        end
        if (is_rop(op))
        begin
          wen   = go;
          wdata = rop_f(raster_function, s0, s1);
        end
        else if (is_key(op))
        begin
          wen   = go && (s0 != s_q.bg);
          wdata = s0;
        end
        else if (op == btr_pkg::OP_FILL)
        begin
          wen   = go;
          wdata = s_q.fg;
        end
        else
        begin
          wen   = go;
          wdata = blend_f(s0, s1, s_q.alpha);
        end
      end
      if (wen)
      begin
        s_d.ram[widx] = wdata;
      end
      if (go)
      begin
        s_d.cnt = s_q.cnt + 7'h01;
        if (s_q.cnt == s_q.len - 7'h01)
        begin
          s_d.fsm  = btr_pkg::ST_IDLE;
          s_d.irqf = 1'b1;
        end
      end
    end

    // Bus data phase. A flag clear is applied only where the engine did not set it.
    if (s_q.aw && s_q.rdy)
    begin
      s_d.aw = 1'b0;
      case (s_q.aa)
        adr(btr_pkg::IDX_CTL0):  start = hwdata[btr_pkg::CTL0_GO_BIT];
        adr(btr_pkg::IDX_CTL1):  if (s_q.fsm == btr_pkg::ST_IDLE) s_d.ctl1 = hwdata[7:0];
        adr(btr_pkg::IDX_INTF):  if (hwdata[btr_pkg::INTF_BTE_BIT] && !s_d.irqf == 1'b0 && s_q.irqf
                                     && s_d.irqf == s_q.irqf && !(go && s_q.cnt == s_q.len - 7'h01))
                                   s_d.irqf = 1'b0;
        adr(btr_pkg::IDX_FG):    s_d.fg = hwdata[15:0];
        adr(btr_pkg::IDX_BG):    s_d.bg = hwdata[15:0];
        adr(btr_pkg::IDX_SRC0):  s_d.s0a = hwdata[5:0];
        adr(btr_pkg::IDX_SRC1):  s_d.s1a = hwdata[5:0];
        adr(btr_pkg::IDX_DEST):  s_d.dta = hwdata[5:0];
        adr(btr_pkg::IDX_LEN):   s_d.len = hwdata[6:0];
        adr(btr_pkg::IDX_ALPHA): s_d.alpha = (hwdata[4:0] > btr_pkg::ALPHA_FULL) ?
                                              btr_pkg::ALPHA_FULL : hwdata[4:0];
        adr(btr_pkg::IDX_MADDR): s_d.maddr = hwdata[5:0];
        // Host loads of the pixel store are dropped while the engine owns it.
        adr(btr_pkg::IDX_MDATA): if (s_q.fsm == btr_pkg::ST_IDLE) s_d.ram[s_q.maddr] = hwdata[15:0];
        default: ;
      endcase
    end
    // A host pixel write waits in a wait state until the previous pixel was taken.
    if (s_q.aw && !s_q.rdy && (!s_d.hv || s_q.fsm == btr_pkg::ST_IDLE))
    begin
      s_d.aw  = 1'b0;
      s_d.rdy = 1'b1;
      if (s_q.fsm == btr_pkg::ST_RUN)
      begin
        s_d.hd = hwdata[15:0];
        s_d.hv = 1'b1;
      end
    end

    // Reserved codes are refused here, so they never raise busy or completion.
    if (start && s_q.fsm == btr_pkg::ST_IDLE && op_ok(op))
    begin
      s_d.cnt = 7'h00;
      s_d.sp  = s_q.s0a;
      s_d.bi  = raster_function;
      s_d.wv  = 1'b0;
      s_d.hv  = 1'b0;
      if (s_q.len == btr_pkg::LEN_RST)
      begin
        s_d.irqf = 1'b1;
      end
      else
      begin
        s_d.fsm = btr_pkg::ST_RUN;
      end
    end

    // Bus address phase.
    if (hsel && htrans[1] && hready)
    begin
      s_d.aa  = (haddr[31:12] == 20'h00000) ? ba : 12'hfff;
      s_d.aw  = hwrite;
      s_d.rdy = !(hwrite && haddr[31:12] == 20'h00000 && ba == adr(btr_pkg::IDX_HDATA));
      s_d.rd  = 32'h00000000;
      if (!hwrite && haddr[31:12] == 20'h00000)
      begin
        case (ba)
          adr(btr_pkg::IDX_STAT):  s_d.rd[btr_pkg::STAT_BUSY_BIT] = (s_q.fsm == btr_pkg::ST_RUN);
          adr(btr_pkg::IDX_INTF):  s_d.rd[btr_pkg::INTF_BTE_BIT] = s_q.irqf;
          adr(btr_pkg::IDX_CTL0):  s_d.rd[btr_pkg::CTL0_GO_BIT] = (s_q.fsm == btr_pkg::ST_RUN);
          adr(btr_pkg::IDX_CTL1):  s_d.rd[7:0] = s_q.ctl1;
          adr(btr_pkg::IDX_FG):    s_d.rd[15:0] = s_q.fg;
          adr(btr_pkg::IDX_BG):    s_d.rd[15:0] = s_q.bg;
          adr(btr_pkg::IDX_SRC0):  s_d.rd[5:0] = s_q.s0a;
          adr(btr_pkg::IDX_SRC1):  s_d.rd[5:0] = s_q.s1a;
          adr(btr_pkg::IDX_DEST):  s_d.rd[5:0] = s_q.dta;
          adr(btr_pkg::IDX_LEN):   s_d.rd[6:0] = s_q.len;
          adr(btr_pkg::IDX_ALPHA): s_d.rd[4:0] = s_q.alpha;
          adr(btr_pkg::IDX_MADDR): s_d.rd[5:0] = s_q.maddr;
          adr(btr_pkg::IDX_MDATA): s_d.rd[15:0] = s_q.ram[s_q.maddr];
          default: ;
        endcase
      end
    end
    s_d.intn = !s_d.irqf;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q       <= '0;
      s_q.ctl1  <= btr_pkg::CTL1_RST;
      s_q.fg    <= btr_pkg::PIX_RST;
      s_q.bg    <= btr_pkg::PIX_RST;
      s_q.alpha <= btr_pkg::ALPHA_FULL;
      s_q.fsm   <= btr_pkg::ST_IDLE;
      s_q.intn  <= 1'b1;
      s_q.rdy   <= 1'b1;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.rdy;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rd;
  assign int_n     = s_q.intn;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_busy_after_start: assert property (start && op_ok(op) && s_q.fsm == btr_pkg::ST_IDLE && ce
                                       && s_q.len != 7'h00 |=> s_q.fsm == btr_pkg::ST_RUN)
    else $error("engine did not turn busy on start");
  a_int_follows_flag: assert property (int_n == !s_q.irqf)
    else $error("interrupt output disagrees with flag");
  a_done_raises_flag: assert property (go && s_q.cnt == s_q.len - 7'h01 && ce
                                       |=> s_q.irqf && s_q.fsm == btr_pkg::ST_IDLE && !int_n)
    else $error("completion did not raise interrupt");
  a_fill_colour: assert property (s_q.fsm == btr_pkg::ST_RUN && op == btr_pkg::OP_FILL
                                  |-> wen && wdata == s_q.fg)
    else $error("solid fill wrote a wrong colour");
  a_rop_pass: assert property (go && is_rop(op) && raster_function == 4'hc |-> wdata == s0)
    else $error("pass raster function altered data");
  a_rop_or: assert property (go && is_rop(op) && raster_function == 4'he |-> wdata == (s0 | s1))
    else $error("or raster function wrong");
  a_rop_zero: assert property (go && is_rop(op) && raster_function == 4'h0 |-> wen && wdata == 16'h0000)
    else $error("zero raster function wrong");
  a_rop_nand: assert property (go && is_rop(op) && raster_function == 4'h7 |-> wdata == ~(s0 & s1))
    else $error("nand raster function wrong");
  a_key_skip: assert property (go && !is_exp(op) && is_key(op) && s0 == s_q.bg |-> !wen)
    else $error("keyed pixel was written");
  a_exp_colour: assert property (go && is_exp(op) |-> wdata == (ebit ? s_q.fg : s_q.bg))
    else $error("expansion chose a wrong colour");
  a_exp_start_bit: assert property (start && s_q.fsm == btr_pkg::ST_IDLE && is_exp(op) && ce
                                    |=> s_q.bi == $past(raster_function))
    else $error("expansion start bit not taken from raster field");
  a_reserved_idle: assert property (start && !op_ok(op) && s_q.fsm == btr_pkg::ST_IDLE
                                    |=> s_q.fsm == btr_pkg::ST_IDLE && !s_q.irqf)
    else $error("reserved code started the engine");

  c_fill_done: cover property (s_q.fsm == btr_pkg::ST_RUN && op == btr_pkg::OP_FILL ##[1:70] s_q.irqf);
  c_key_skip: cover property (go && is_key(op) && !wen);
  c_host_stall: cover property (s_q.aw && !s_q.rdy ##1 !s_q.rdy);

endmodule // btr_engine

// ==== test/btr_host.sv ====
module btr_host (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master signals
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Callers start a transfer in the time step of a rising edge; ready and read data are taken at rising edges.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
endmodule // btr_host

// ==== test/btr_engine_tb.sv ====
module btr_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        int_n;
  logic        ce;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          miscompares;
  int          tests_run;

  localparam logic [15:0] VA = 16'hff00;
  localparam logic [15:0] VB = 16'hf0f0;
  localparam logic [15:0] FGC = 16'h1234;
  localparam logic [15:0] OLD = 16'h0bad;

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  btr_host i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
                   .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  btr_engine i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
                    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_n(int_n));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got & m, exp);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    i_host.xfer(1'b1, i, d, rd);
  endtask

  task automatic chk(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m);
    i_host.xfer(1'b0, i, 32'h0, rd);
    cmp(rd, e, m);
  endtask

  task automatic poke(input logic [5:0] a, input logic [15:0] d);
    wr(btr_pkg::IDX_MADDR, {26'h0, a});
    wr(btr_pkg::IDX_MDATA, {16'h0, d});
  endtask

  task automatic pix(input logic [5:0] a, input logic [15:0] e);
    wr(btr_pkg::IDX_MADDR, {26'h0, a});
    chk(btr_pkg::IDX_MDATA, {16'h0, e}, 32'hffffffff);
  endtask

  task automatic start(input logic [7:0] c1, input logic [5:0] s0, input logic [5:0] dt, input logic [6:0] n);
    wr(btr_pkg::IDX_SRC0, {26'h0, s0});
    wr(btr_pkg::IDX_SRC1, 32'h1);
    wr(btr_pkg::IDX_DEST, {26'h0, dt});
    wr(btr_pkg::IDX_LEN, {25'h0, n});
    wr(btr_pkg::IDX_CTL1, {24'h0, c1});
    wr(btr_pkg::IDX_CTL0, 32'h10);
  endtask

  task automatic busy_wait;
    int k;
    for (k = 0; k < 200; k++)
    begin
      i_host.xfer(1'b0, btr_pkg::IDX_STAT, 32'h0, rd);
      if (rd[3] === 1'b0)
        break;
    end
    cmp(rd, 32'h0, 32'h8);
  endtask

  task automatic fin;
    busy_wait();
    wr(btr_pkg::IDX_INTF, 32'h2);
  endtask

  // Expected raster result: each code bit is the output for one pair of source bits.
  function automatic logic [15:0] raster_function(input logic [3:0] c, input logic [15:0] a, input logic [15:0] b);
    logic [15:0] r;
    for (int k = 0; k < 16; k++)
      r[k] = c[{a[k], b[k]}];
    return r;
  endfunction

  initial
  begin
    #(40 * 20000);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    hresetn = 1'b0;
    ce      = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    cmp({31'h0, int_n}, 32'h1, 32'h1);
    chk(btr_pkg::IDX_STAT, 32'h0, 32'h8);
    chk(8'h02, 32'h0, 32'hffffffff);
    poke(6'd0, VA);
    poke(6'd1, VB);
    poke(6'd3, 16'h0002);
    for (int k = 4; k < 64; k++)
      poke(k[5:0], OLD);
    wr(btr_pkg::IDX_FG, {16'h0, FGC});
    wr(btr_pkg::IDX_BG, {16'h0, VA});
    start(8'h0c, 6'd0, 6'd4, 7'd2);
    busy_wait();
    cmp({31'h0, int_n}, 32'h0, 32'h1);
    chk(btr_pkg::IDX_INTF, 32'h2, 32'h2);
    wr(btr_pkg::IDX_INTF, 32'h2);
    // The clear lands at the edge that ends the write, so the pin is looked at one edge later.
    @(posedge hclk);
    cmp({31'h0, int_n}, 32'h1, 32'h1);
    pix(6'd4, FGC);
    pix(6'd5, FGC);
    pix(6'd6, OLD);
    start(8'hc0, 6'd0, 6'd10, 7'd1);
    chk(btr_pkg::IDX_STAT, 32'h8, 32'h8);
    chk(btr_pkg::IDX_CTL0, 32'h10, 32'h10);
    wr(btr_pkg::IDX_HDATA, 32'h5a5a);
    fin();
    pix(6'd10, 16'h5a5a);
    for (int c = 0; c < 16; c++)
    begin
      start({c[3:0], 4'h2}, 6'd0, 6'd16 + c[5:0], 7'd1);
      fin();
      pix(6'd16 + c[5:0], raster_function(c[3:0], VA, VB));
    end
    start(8'h05, 6'd0, 6'd40, 7'd2);
    fin();
    pix(6'd40, OLD);
    pix(6'd41, VB);
    start(8'h04, 6'd0, 6'd42, 7'd2);
    wr(btr_pkg::IDX_HDATA, {16'h0, VA});
    wr(btr_pkg::IDX_HDATA, {16'h0, VB});
    fin();
    pix(6'd42, OLD);
    pix(6'd43, VB);
    start(8'he8, 6'd0, 6'd44, 7'd2);
    wr(btr_pkg::IDX_HDATA, 32'h4000);
    fin();
    pix(6'd44, FGC);
    pix(6'd45, VA);
    start(8'he9, 6'd0, 6'd46, 7'd2);
    wr(btr_pkg::IDX_HDATA, 32'h4000);
    fin();
    pix(6'd46, FGC);
    pix(6'd47, OLD);
    start(8'h0e, 6'd3, 6'd48, 7'd2);
    fin();
    pix(6'd48, VA);
    pix(6'd49, FGC);
    start(8'h0f, 6'd3, 6'd50, 7'd2);
    fin();
    pix(6'd50, OLD);
    pix(6'd51, FGC);
    wr(btr_pkg::IDX_ALPHA, 32'h10);
    start(8'h0a, 6'd0, 6'd52, 7'd1);
    fin();
    pix(6'd52, VA);
    start(8'h0b, 6'd0, 6'd54, 7'd1);
    wr(btr_pkg::IDX_HDATA, 32'h00c7);
    fin();
    pix(6'd54, 16'h00c7);
    wr(btr_pkg::IDX_ALPHA, 32'h0);
    start(8'h0a, 6'd0, 6'd53, 7'd1);
    fin();
    pix(6'd53, VB);
    start(8'hc6, 6'd0, 6'd55, 7'd1);
    fin();
    pix(6'd55, VA);
    start(8'h07, 6'd0, 6'd56, 7'd1);
    fin();
    pix(6'd56, OLD);
    start(8'h03, 6'd0, 6'd57, 7'd1);
    chk(btr_pkg::IDX_STAT, 32'h0, 32'h8);
    chk(btr_pkg::IDX_INTF, 32'h0, 32'h2);
    pix(6'd57, OLD);
    // A freeze longer than the whole fill must leave the engine busy once the clock enable returns.
    start(8'h0c, 6'd0, 6'd10, 7'd50);
    ce <= 1'b0;
    repeat (60) @(posedge hclk);
    ce <= 1'b1;
    chk(btr_pkg::IDX_STAT, 32'h8, 32'h8);
    fin();
    pix(6'd59, FGC);
    wrap_up();
  end
endmodule // btr_engine_tb
